// >>> cmd_top.sv
`include "cmd_defs.svh"

module cmd_top
  import cmd_pkg::*;
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire logic [`CMD_NUM_CNT-1:0] cnt_src,
  input  wire logic [`CMD_NUM_CNT-1:0] cnt_gate,
  output logic [`CMD_NUM_CNT-1:0]      cnt_tc,
  output logic [4:0]                   scaler_tick
);

  cmd_bus_state_t bus_ff;
  logic [7:0]     adr_ff;
  logic [31:0]    hrdata_ff;
  logic [15:0]    mm_ff;
  logic [2:0]     ptr_cnt_ff;
  logic [1:0]     ptr_el_ff;
  logic [15:0]    mode_ff [`CMD_NUM_CNT];
  logic [15:0]    load_ff [`CMD_NUM_CNT];
  logic [15:0]    hold_ff [`CMD_NUM_CNT];
  logic [15:0]    count_w [`CMD_NUM_CNT];
  logic [`CMD_NUM_CNT-1:0] armed_w;
  logic [`CMD_NUM_CNT-1:0] tc_w;
  logic [`CMD_NUM_CNT-1:0] arm_p;
  logic [`CMD_NUM_CNT-1:0] disarm_p;
  logic [`CMD_NUM_CNT-1:0] load_p;
  logic           addr_ok;
  logic           wr_en;
  logic           rd_cap;
  logic           cmd_wr;
  logic [2:0]     opcode;
  logic [4:0]     arg;
  logic           data_wr;
  logic           data_acc;
  logic           seq_dis;
  logic [15:0]    data_rd;
  logic [31:0]    rd_mux;
  logic [2:0]     nxt_ptr_cnt;
  logic [1:0]     nxt_ptr_el;

  // address phase accepted while the bus is ready
  assign addr_ok = hsel && hready && htrans[1];
  assign wr_en   = (bus_ff == CMD_BUS_WRITE);
  assign rd_cap  = (bus_ff == CMD_BUS_RD_WAIT);

  // bus phase tracking: writes take no wait, reads take one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_ff <= CMD_BUS_IDLE;
    end else begin
      case (bus_ff)
        CMD_BUS_RD_WAIT: begin
          bus_ff <= CMD_BUS_RD_DONE;
        end
        default: begin
          if (addr_ok) begin
            bus_ff <= hwrite ? CMD_BUS_WRITE : CMD_BUS_RD_WAIT;
          end else begin
            bus_ff <= CMD_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // latched address of the pending data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adr_ff <= 8'h00;
    end else if (addr_ok) begin
      adr_ff <= haddr[7:0];
    end
  end

  // bus answers
  assign hreadyout = (bus_ff != CMD_BUS_RD_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // command decode
  assign cmd_wr  = wr_en && (adr_ff == `CMD_ADDR_COMMAND);
  assign opcode  = hwdata[7:5];
  assign arg     = hwdata[4:0];
  assign data_wr = wr_en && (adr_ff == `CMD_ADDR_DATA);
  assign data_acc = data_wr || (rd_cap && adr_ff == `CMD_ADDR_DATA);
  assign seq_dis = mm_ff[`CMD_MM_AUTOSEQ_DIS];

  // per-counter command pulses
  always_comb begin
    for (int i = 0; i < `CMD_NUM_CNT; i++) begin
      arm_p[i]    = cmd_wr && (opcode == `CMD_OP_ARM) && arg[i];
      disarm_p[i] = cmd_wr && arg[i] && (opcode == `CMD_OP_DISARM);
      load_p[i]   = cmd_wr && (opcode == `CMD_OP_LOAD) && arg[i];
    end
    if (cmd_wr && opcode == `CMD_OP_MASTER_RST) begin
      disarm_p = '1;
    end
  end

  // master mode register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mm_ff <= `CMD_MM_RESET;
    end else if (wr_en && adr_ff == `CMD_ADDR_MASTER) begin
      mm_ff <= hwdata[15:0];
    end else if (cmd_wr && opcode == `CMD_OP_MASTER_RST) begin
      mm_ff <= `CMD_MM_RESET;
    end else if (cmd_wr && opcode == `CMD_OP_SEQ_OFF) begin
      mm_ff[`CMD_MM_AUTOSEQ_DIS] <= 1'b1;
    end else if (cmd_wr && opcode == `CMD_OP_SEQ_ON) begin
      mm_ff[`CMD_MM_AUTOSEQ_DIS] <= 1'b0;
    end
  end

  // next pointer for auto-sequencing: element, then counter
  always_comb begin
    nxt_ptr_el  = ptr_el_ff + 2'h1;
    nxt_ptr_cnt = ptr_cnt_ff;
    if (ptr_el_ff == `CMD_EL_COUNT) begin
      nxt_ptr_cnt = (ptr_cnt_ff >= `CMD_LAST_CNT) ? 3'h0 : ptr_cnt_ff + 3'h1;
    end
  end

  // data pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_cnt_ff <= 3'h0;
      ptr_el_ff  <= 2'h0;
    end else if (cmd_wr && opcode == `CMD_OP_PTR_LOAD) begin
      ptr_cnt_ff <= (arg[4:2] > `CMD_LAST_CNT) ? `CMD_LAST_CNT : arg[4:2];
      ptr_el_ff  <= arg[1:0];
    end else if (data_acc && !seq_dis) begin
      ptr_cnt_ff <= nxt_ptr_cnt;
      ptr_el_ff  <= nxt_ptr_el;
    end
  end

  // counter mode, load and hold storage through the data port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `CMD_NUM_CNT; i++) begin
        mode_ff[i] <= 16'h0000;
        load_ff[i] <= 16'h0000;
        hold_ff[i] <= 16'h0000;
      end
    end else if (data_wr) begin
      case (ptr_el_ff)
        `CMD_EL_MODE: mode_ff[ptr_cnt_ff] <= hwdata[15:0];
        `CMD_EL_LOAD: load_ff[ptr_cnt_ff] <= hwdata[15:0];
        `CMD_EL_HOLD: hold_ff[ptr_cnt_ff] <= hwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // data port read selection
  always_comb begin
    case (ptr_el_ff)
      `CMD_EL_MODE: data_rd = mode_ff[ptr_cnt_ff];
      `CMD_EL_LOAD: data_rd = load_ff[ptr_cnt_ff];
      `CMD_EL_HOLD: data_rd = hold_ff[ptr_cnt_ff];
      default:      data_rd = count_w[ptr_cnt_ff];
    endcase
  end

  // register read mux, unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (adr_ff)
      `CMD_ADDR_MASTER: rd_mux[15:0] = mm_ff;
      `CMD_ADDR_DATA: rd_mux[15:0] = data_rd;
      `CMD_ADDR_POINTER: rd_mux[4:0] = {ptr_cnt_ff, ptr_el_ff};
      `CMD_ADDR_STATUS: begin
        rd_mux[`CMD_ST_ARMED_LO +: `CMD_NUM_CNT] = armed_w;
        rd_mux[`CMD_ST_TC_LO +: `CMD_NUM_CNT]    = tc_w;
        rd_mux[`CMD_ST_SEQ_DIS]                  = seq_dis;
      end
      default: begin
      end
    endcase
  end

  // read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_cap) begin
      hrdata_ff <= rd_mux;
    end
  end

  // five independent counters
  for (genvar g = 0; g < `CMD_NUM_CNT; g++) begin : g_cnt
    cmd_counter u_cnt (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .mode     (mode_ff[g]),
      .load_val (load_ff[g]),
      .hold_val (hold_ff[g]),
      .arm_p    (arm_p[g]),
      .disarm_p (disarm_p[g]),
      .load_p   (load_p[g]),
      .src      (cnt_src[g]),
      .gate     (cnt_gate[g]),
      .count_ff (count_w[g]),
      .armed_ff (armed_w[g]),
      .tc_ff    (tc_w[g])
    );
  end

  assign cnt_tc = tc_w;

  // frequency scaler
  cmd_scaler u_scaler (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bcd_sel (mm_ff[`CMD_MM_SCALER_BCD]),
    .tick_ff (scaler_tick)
  );

endmodule

// >>> cmd_defs.svh
`ifndef CMD_DEFS_SVH
`define CMD_DEFS_SVH

// register byte addresses
`define CMD_ADDR_MASTER   8'h00
`define CMD_ADDR_COMMAND  8'h04
`define CMD_ADDR_DATA     8'h08
`define CMD_ADDR_POINTER  8'h0C
`define CMD_ADDR_STATUS   8'h10

// sizes
`define CMD_NUM_CNT       5
`define CMD_LAST_CNT      3'h4
`define CMD_DIGITS        4

// master mode field positions and reset value
`define CMD_MM_AUTOSEQ_DIS  14
`define CMD_MM_SCALER_BCD   15
`define CMD_MM_RESET        16'h0000

// counter mode field positions
`define CMD_CM_GATE_HI      15
`define CMD_CM_GATE_LO      13
`define CMD_CM_SPECIAL      7
`define CMD_CM_RELOAD       6
`define CMD_CM_REPEAT       5

// gate control encodings
`define CMD_GC_NONE         3'h0
`define CMD_GC_LEVEL_LOW    3'h2
`define CMD_GC_EDGE_RISE    3'h6
`define CMD_GC_EDGE_FALL    3'h7

// pointer elements
`define CMD_EL_MODE         2'h0
`define CMD_EL_LOAD         2'h1
`define CMD_EL_HOLD         2'h2
`define CMD_EL_COUNT        2'h3

// command opcodes in hwdata[7:5], argument in hwdata[4:0]
`define CMD_OP_ARM          3'h0
`define CMD_OP_DISARM       3'h1
`define CMD_OP_LOAD         3'h2
`define CMD_OP_PTR_LOAD     3'h3
`define CMD_OP_SEQ_OFF      3'h4
`define CMD_OP_SEQ_ON       3'h5
`define CMD_OP_MASTER_RST   3'h7

// scaler digit limits
`define CMD_DIG_BIN_MAX     4'hF
`define CMD_DIG_BCD_MAX     4'h9

// status field positions
`define CMD_ST_ARMED_LO     0
`define CMD_ST_TC_LO        8
`define CMD_ST_SEQ_DIS      16

`endif

// >>> cmd_pkg.sv
`include "cmd_defs.svh"

package cmd_pkg;

  typedef enum logic [1:0] {
    CMD_GATE_NONE,
    CMD_GATE_LEVEL,
    CMD_GATE_EDGE
  } cmd_gate_kind_t;

  typedef enum logic [1:0] {
    CMD_BUS_IDLE,
    CMD_BUS_WRITE,
    CMD_BUS_RD_WAIT,
    CMD_BUS_RD_DONE
  } cmd_bus_state_t;

  // classify a gate control field
  function automatic cmd_gate_kind_t cmd_gate_kind(input logic [2:0] gc);
    if (gc == `CMD_GC_NONE) begin
      return CMD_GATE_NONE;
    end else if (gc[2] && gc[1]) begin
      return CMD_GATE_EDGE;
    end else begin
      return CMD_GATE_LEVEL;
    end
  endfunction

  // gate level seen as active for a level gating code
  function automatic logic cmd_gate_level_on(input logic [2:0] gc, input logic gate);
    if (gc == `CMD_GC_LEVEL_LOW) begin
      return ~gate;
    end else begin
      return gate;
    end
  endfunction

endpackage

// >>> cmd_scaler.sv
`include "cmd_defs.svh"

module cmd_scaler
  import cmd_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       bcd_sel,
  output logic [4:0]      tick_ff
);

  logic [3:0] digit_ff [`CMD_DIGITS];
  logic [3:0] dig_max;
  logic [`CMD_DIGITS:0] carry;

  // each stage divides by sixteen in binary, by ten in bcd
  assign dig_max = bcd_sel ? `CMD_DIG_BCD_MAX : `CMD_DIG_BIN_MAX;

  // ripple carry: a stage steps when every lower stage wraps
  always_comb begin
    carry[0] = 1'b1;
    for (int i = 0; i < `CMD_DIGITS; i++) begin
      carry[i+1] = carry[i] && (digit_ff[i] >= dig_max);
    end
  end

  // digit chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `CMD_DIGITS; i++) begin
        digit_ff[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < `CMD_DIGITS; i++) begin
        if (carry[i]) begin
          digit_ff[i] <= (digit_ff[i] >= dig_max) ? 4'h0 : digit_ff[i] + 4'h1;
        end
      end
    end
  end

  // one-cycle ticks of the five subfrequencies
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_ff <= 5'h00;
    end else begin
      tick_ff <= carry;
    end
  end

endmodule

// >>> cmd_counter.sv
`include "cmd_defs.svh"

module cmd_counter
  import cmd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] mode,
  input  wire logic [15:0] load_val,
  input  wire logic [15:0] hold_val,
  input  wire logic        arm_p,
  input  wire logic        disarm_p,
  input  wire logic        load_p,
  input  wire logic        src,
  input  wire logic        gate,
  output logic [15:0]      count_ff,
  output logic             armed_ff,
  output logic             tc_ff
);

  logic           src_d_ff;
  logic           gate_d_ff;
  logic           started_ff;
  logic           sel_hold_ff;
  logic           tc_seen_ff;
  logic [2:0]     gc;
  cmd_gate_kind_t kind;
  logic           rs;
  logic           rep;
  logic           src_edge;
  logic           gate_edge;
  logic           gate_ok;
  logic           count_en;
  logic           hit_tc;
  logic           finish;
  logic [15:0]    reload;

  // mode field decode, private to this counter
  assign gc   = mode[`CMD_CM_GATE_HI:`CMD_CM_GATE_LO];
  assign kind = cmd_gate_kind(gc);
  assign rs   = mode[`CMD_CM_RELOAD];
  assign rep  = mode[`CMD_CM_REPEAT];

  // edge detection on the synchronous pins
  assign src_edge  = src && !src_d_ff;
  assign gate_edge = (gc == `CMD_GC_EDGE_FALL) ? (!gate && gate_d_ff) : (gate && !gate_d_ff);

  // gating per mode
  always_comb begin
    case (kind)
      CMD_GATE_NONE:  gate_ok = 1'b1;
      CMD_GATE_LEVEL: gate_ok = cmd_gate_level_on(gc, gate);
      CMD_GATE_EDGE:  gate_ok = started_ff;
      default:        gate_ok = 1'b0;
    endcase
  end

  // a counter in terminal count always takes the next edge
  assign count_en = src_edge && ((armed_ff && gate_ok) || tc_ff);
  assign hit_tc   = count_en && (count_ff == 16'h0001);
  assign finish   = hit_tc && (!rs || tc_seen_ff);
  assign reload   = (rs && sel_hold_ff) ? hold_val : load_val;

  // pin history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_d_ff  <= 1'b0;
      gate_d_ff <= 1'b0;
    end else begin
      src_d_ff  <= src;
      gate_d_ff <= gate;
    end
  end

  // count register with reload at terminal count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= 16'h0000;
    end else if (load_p) begin
      count_ff <= load_val;
    end else if (hit_tc) begin
      count_ff <= reload;
    end else if (count_en) begin
      count_ff <= count_ff - 16'h0001;
    end
  end

  // terminal count interval lasts until the next counted edge or a load command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tc_ff <= 1'b0;
    end else if (count_en || load_p) begin
      tc_ff <= hit_tc;
    end
  end

  // reload source alternation and terminal count pairing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_hold_ff <= 1'b1;
      tc_seen_ff  <= 1'b0;
    end else if (load_p || arm_p) begin
      sel_hold_ff <= 1'b1;
      tc_seen_ff  <= 1'b0;
    end else if (hit_tc) begin
      sel_hold_ff <= !sel_hold_ff;
      tc_seen_ff  <= rs && !tc_seen_ff;
    end
  end

  // arming: software arm wins over a hardware disarm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_ff <= 1'b0;
    end else if (arm_p) begin
      armed_ff <= 1'b1;
    end else if (disarm_p) begin
      armed_ff <= 1'b0;
    end else if (finish && !rep) begin
      armed_ff <= 1'b0;
    end
  end

  // edge gated start and stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      started_ff <= 1'b0;
    end else if (arm_p || disarm_p || kind != CMD_GATE_EDGE) begin
      started_ff <= 1'b0;
    end else if (armed_ff && gate_edge) begin
      started_ff <= 1'b1;
    end else if (finish) begin
      started_ff <= 1'b0;
    end
  end

endmodule

// >>> cmd_props.sv
`include "cmd_defs.svh"

module cmd_props
  import cmd_pkg::*;
(
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic [`CMD_NUM_CNT-1:0] cnt_src,
  input wire logic [`CMD_NUM_CNT-1:0] cnt_tc,
  input wire logic [4:0]              scaler_tick
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // accepted transfers by direction
  logic rd_req;
  logic wr_req;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  assign wr_req = hsel && hready && htrans[1] && hwrite;

  // read data phase: one wait cycle, then ready
  sequence rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence

  read_wait_a: assert property (rd_req |=> rd_ans)
    else $error("read data phase timing wrong");
  write_ready_a: assert property (wr_req |=> hreadyout)
    else $error("write data phase stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  tick_base_a: assert property ($past(hresetn) |-> scaler_tick[0])
    else $error("base scaler tick missing");
  tick_chain_a: assert property (scaler_tick[2] |-> scaler_tick[1])
    else $error("scaler stage ticked without lower stage");
  tick_gap_a: assert property (scaler_tick[1] |=> !scaler_tick[1] [*8])
    else $error("scaler first stage ticked too soon");
  tick_due_a: assert property (scaler_tick[1] |-> ##[10:16] scaler_tick[1])
    else $error("scaler first stage tick late");
  tc_hold_a: assert property (cnt_tc[0] && !$rose(cnt_src[0]) |=> cnt_tc[0])
    else $error("terminal count dropped without source edge");

  // terminal count only follows a counted rising source edge
  for (genvar i = 0; i < `CMD_NUM_CNT; i++) begin : g_tc
    tc_cause_a: assert property ($rose(cnt_tc[i]) |->
      $past(cnt_src[i]) && !$past(cnt_src[i], 2))
      else $error("terminal count without source edge");
  end
endmodule

bind cmd_top cmd_props i_cmd_props (
  .hclk        (hclk),
  .hresetn     (hresetn),
  .hsel        (hsel),
  .htrans      (htrans),
  .hwrite      (hwrite),
  .hready      (hready),
  .hreadyout   (hreadyout),
  .hresp       (hresp),
  .cnt_src     (cnt_src),
  .cnt_tc      (cnt_tc),
  .scaler_tick (scaler_tick)
);

// >>> cmd_host_model.sv
module cmd_host_model
  import cmd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // one single word transfer; released lines flip so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= w ? d : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule

// >>> counter_mode_decode_bench.sv
`include "cmd_defs.svh"

module counter_mode_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  cnt_src, cnt_gate, cnt_tc, scaler_tick;
  logic [15:0] ld, mm;
  int          num_errors, n_checks, gap;

  // 50 ns clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  cmd_top i_cmd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cnt_src(cnt_src),
    .cnt_gate(cnt_gate), .cnt_tc(cnt_tc), .scaler_tick(scaler_tick));

  cmd_host_model i_cmd_host_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_cmd_host_model.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a);
    i_cmd_host_model.xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic cmd(input logic [2:0] op, input logic [4:0] arg);
    wr(`CMD_ADDR_COMMAND, {24'h0, op, arg});
  endtask

  function automatic logic [31:0] ptr(input logic [2:0] c, input logic [1:0] e);
    return {27'h0, c, e};
  endfunction

  function automatic int exp_gap(input logic bcd);
    return bcd ? int'(`CMD_DIG_BCD_MAX) + 1 : int'(`CMD_DIG_BIN_MAX) + 1;
  endfunction

  // mode, load, hold through the auto-advancing pointer, then load and arm
  task automatic prog(input logic [2:0] c, input logic [15:0] m, input logic [15:0] l,
                      input logic [15:0] h);
    cmd(`CMD_OP_PTR_LOAD, {c, `CMD_EL_MODE});
    wr(`CMD_ADDR_DATA, {16'h0, m});  // special gate always 0
    wr(`CMD_ADDR_DATA, {16'h0, l});
    wr(`CMD_ADDR_DATA, {16'h0, h});
    cmd(`CMD_OP_LOAD, 5'h1 << c);
    cmd(`CMD_OP_ARM, 5'h1 << c);
  endtask

  task automatic rdcnt(input logic [2:0] c);
    cmd(`CMD_OP_PTR_LOAD, {c, `CMD_EL_COUNT});
    rd(`CMD_ADDR_DATA);
  endtask

  task automatic pulse(input int i, input int n);
    repeat (n) begin
      cnt_src[i] <= 1'b1;
      repeat (2) @(posedge hclk);
      cnt_src[i] <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask

  // cycles between ticks of scaler stage s
  task automatic tgap(input int s);
    @(posedge hclk);
    while (scaler_tick[s] !== 1'b1) @(posedge hclk);
    gap = 0;
    do begin
      @(posedge hclk);
      gap++;
    end while (scaler_tick[s] !== 1'b1);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    gap = $urandom(32'h7AC4);
    num_errors = 0;
    n_checks = 0;
    hresetn = 1'b0;
    cnt_src = 5'h00;
    cnt_gate = 5'h00;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`CMD_ADDR_MASTER);
    check(q, 32'h0);
    rd(`CMD_ADDR_STATUS);
    check(q, 32'h0);
    mm = 16'($urandom());
    mm[15:14] = 2'h1;
    wr(`CMD_ADDR_MASTER, {16'h0, mm});
    rd(`CMD_ADDR_MASTER);
    check(q, {16'h0, mm});
    cmd(`CMD_OP_SEQ_ON, 5'h00);
    rd(`CMD_ADDR_MASTER);
    check(q, {18'h0, mm[13:0]});
    cmd(`CMD_OP_SEQ_OFF, 5'h00);
    rd(`CMD_ADDR_STATUS);
    check(q[16], 1'b1);
    // pointer frozen while auto-sequence is off
    cmd(`CMD_OP_PTR_LOAD, {3'h2, 2'h1});
    rd(`CMD_ADDR_DATA);
    wr(`CMD_ADDR_DATA, 32'h0);
    rd(`CMD_ADDR_POINTER);
    check(q, ptr(3'h2, 2'h1));
    cmd(`CMD_OP_SEQ_ON, 5'h00);
    cmd(`CMD_OP_PTR_LOAD, {3'h4, 2'h2});
    rd(`CMD_ADDR_DATA);
    rd(`CMD_ADDR_POINTER);
    check(q, ptr(3'h4, 2'h3));
    wr(`CMD_ADDR_DATA, 32'h0);
    rd(`CMD_ADDR_POINTER);
    check(q, ptr(3'h0, 2'h0));
    // single shot, no gating
    ld = 16'($urandom_range(5, 2));
    prog(3'h0, 16'h0000, ld, 16'h0);
    pulse(0, ld - 1);
    check(cnt_tc[0], 1'b0);
    pulse(0, 1);
    check(cnt_tc[0], 1'b1);
    rd(`CMD_ADDR_STATUS);
    check(q[0], 1'b0);
    pulse(0, 1);
    rdcnt(3'h0);
    check(q, {16'h0, ld - 16'h1});
    pulse(0, ld);
    check(cnt_tc[0], 1'b0);
    // twice to terminal count, alternating reload
    prog(3'h1, 16'h0040, 16'h2, 16'h3);
    pulse(1, 2);
    rdcnt(3'h1);
    check(q, 32'h3);
    rd(`CMD_ADDR_STATUS);
    check(q[1], 1'b1);
    pulse(1, 3);
    check(cnt_tc[1], 1'b1);
    rdcnt(3'h1);
    check(q, 32'h2);
    rd(`CMD_ADDR_STATUS);
    check(q[1], 1'b0);
    // repetition never disarms
    prog(3'h2, 16'h0020, 16'h2, 16'h0);
    repeat (3) begin
      pulse(2, 2);
      check(cnt_tc[2], 1'b1);
    end
    // level gating, active high
    prog(3'h3, 16'h2000, 16'h2, 16'h0);
    pulse(3, 3);
    rdcnt(3'h3);
    check(q, 32'h2);
    cnt_gate[3] <= 1'b1;
    pulse(3, 2);
    check(cnt_tc[3], 1'b1);
    // rising edge gating, stop at next terminal count
    prog(3'h4, 16'hC000, 16'h2, 16'h0);
    pulse(4, 3);
    check(cnt_tc[4], 1'b0);
    cnt_gate[4] <= 1'b1;
    @(posedge hclk);
    pulse(4, 2);
    check(cnt_tc[4], 1'b1);
    pulse(4, 3);
    rdcnt(3'h4);
    check(q, 32'h1);
    // edge gating with alternate reload: stop at second terminal count
    prog(3'h4, 16'hC040, 16'h2, 16'h3);
    cnt_gate[4] <= 1'b0;
    repeat (2) @(posedge hclk);
    cnt_gate[4] <= 1'b1;
    @(posedge hclk);
    pulse(4, 2);
    check(cnt_tc[4], 1'b1);
    pulse(4, 3);
    check(cnt_tc[4], 1'b1);
    rd(`CMD_ADDR_STATUS);
    check(q[4:0], 5'h04);
    cmd(`CMD_OP_MASTER_RST, 5'h00);
    rd(`CMD_ADDR_STATUS);
    check(q[4:0], 5'h00);
    // level gating active low, then falling edge gating
    prog(3'h3, 16'h4000, 16'h2, 16'h0);
    pulse(3, 2);
    rdcnt(3'h3);
    check(q, 32'h2);
    cnt_gate[3] <= 1'b0;
    pulse(3, 2);
    check(cnt_tc[3], 1'b1);
    prog(3'h4, 16'hE000, 16'h2, 16'h0);
    cnt_gate[4] <= 1'b0;
    repeat (2) @(posedge hclk);
    pulse(4, 2);
    check(cnt_tc[4], 1'b1);
    // scaler step ratio in both settings
    wr(`CMD_ADDR_MASTER, 32'h8000);
    tgap(1);
    tgap(1);
    check(gap, exp_gap(1'b1));
    tgap(2);
    tgap(2);
    check(gap, exp_gap(1'b1) * exp_gap(1'b1));
    wr(`CMD_ADDR_MASTER, 32'h0);
    tgap(1);
    tgap(1);
    check(gap, exp_gap(1'b0));
    tgap(2);
    tgap(2);
    check(gap, exp_gap(1'b0) * exp_gap(1'b0));
    end_of_test();
  end
endmodule
